// [include/mmd_pkg.sv]
// constants, types and state layout of the memory map decoder
`default_nettype none

package mmd_pkg;

   // ==========================================================
   // address map, 1-Mbyte space, largest variant
   typedef logic [19:0] mmd_addr_t;
   localparam mmd_addr_t BASE_END    = 20'h0FFFF;
   localparam mmd_addr_t VEC_BASE    = 20'h00000;
   localparam mmd_addr_t VEC_END     = 20'h0003F;
   localparam mmd_addr_t TCALL_BASE  = 20'h00040;
   localparam mmd_addr_t TCALL_END   = 20'h0007F;
   localparam mmd_addr_t FCALL_BASE  = 20'h00800;
   localparam mmd_addr_t FCALL_END   = 20'h00FFF;
   localparam mmd_addr_t ROM_END     = 20'h1FFFF;
   localparam mmd_addr_t DATA_LO     = 20'h0EE00;
   localparam mmd_addr_t NOFETCH_LO  = 20'h0FD00;
   localparam mmd_addr_t DATA_HI_OFS = 20'hF0000;
   localparam mmd_addr_t SPACE_END   = 20'hFFFFF;

   // ==========================================================
   // register port
   localparam logic [1:0] REG_MODE   = 2'h0;
   localparam logic [1:0] REG_PLACE  = 2'h1;
   localparam logic [1:0] REG_STATUS = 2'h2;
   localparam int         MODE_FAST_BIT = 0;
   localparam int         MODE_EXP_BIT  = 1;
   localparam int         MODE_WAIT_LSB = 2;
   localparam int         PLACE_UP_BIT  = 0;
   localparam int         STAT_FLT_BIT  = 0;
   localparam logic [7:0] MODE_RST   = 8'h00;

   // ==========================================================
   // access timing in system clocks
   localparam logic [3:0] FAST_FETCH_CLKS = 4'h2;
   localparam logic [3:0] EXT_FETCH_CLKS  = 4'h3;
   localparam logic [3:0] DATA_CLKS       = 4'h1;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      TGT_DATA = 2'b00,
      TGT_ROM  = 2'b01,
      TGT_EXT  = 2'b10,
      TGT_NONE = 2'b11
   } mmd_tgt_t;

   typedef enum logic [2:0] {
      KIND_DATA  = 3'b000,
      KIND_FETCH = 3'b001,
      KIND_VEC   = 3'b010,
      KIND_TCALL = 3'b011,
      KIND_FCALL = 3'b100
   } mmd_kind_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } mmd_st_t;

   typedef struct packed {
      mmd_kind_t   kind;
      mmd_addr_t   addr;
      logic [10:0] idx;
   } mmd_req_t;

   typedef struct packed {
      logic      done;
      logic      fault;
      logic      vec;
      logic      base;
      mmd_tgt_t  target;
      mmd_addr_t addr;
   } mmd_resp_t;

   typedef struct packed {
      mmd_st_t    st;
      logic       ready;
      logic       fast;
      logic       expand;
      logic [1:0] wait_n;
      logic       upper;
      logic       locked;
      logic       fault_flag;
      logic [3:0] cnt;
      logic [7:0] rdata;
      mmd_resp_t  resp;
   } mmd_state_t;

endpackage : mmd_pkg

`default_nettype wire

// [logic/mmd_region.sv]
// combinational region decode of one address
`default_nettype none

module mmd_region (
   // address and configuration
   input  wire  mmd_pkg::mmd_addr_t i_addr,
   input  wire  logic               i_upper,
   input  wire  logic               i_expand,
   // decode result
   output var   mmd_pkg::mmd_tgt_t  o_target,
   output var   logic               o_no_fetch,
   output var   logic               o_base
);
   import mmd_pkg::*;

   mmd_addr_t data_lo;
   mmd_addr_t data_hi;
   mmd_addr_t nofetch_lo;
   logic      in_data;

   always_comb begin
      // upper placement moves the whole data area to the top
      data_lo    = i_upper ? (DATA_LO | DATA_HI_OFS) : DATA_LO;
      data_hi    = i_upper ? SPACE_END : BASE_END;
      nofetch_lo = i_upper ? (NOFETCH_LO | DATA_HI_OFS) : NOFETCH_LO;
      in_data    = (i_addr >= data_lo) && (i_addr <= data_hi);
      o_no_fetch = in_data && (i_addr >= nofetch_lo);
      o_base     = (i_addr <= BASE_END);
      // data area first, then rom, then external bus
      if (in_data) begin
         o_target = TGT_DATA;
      end else if (i_addr <= ROM_END) begin
         o_target = TGT_ROM;
      end else if (i_expand) begin
         o_target = TGT_EXT;
      end else begin
         o_target = TGT_NONE;
      end
   end

endmodule : mmd_region

`default_nettype wire

// [logic/mmd_decoder.sv]
// memory map decoder: placement, target select and fetch timing
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`default_nettype none

module mmd_decoder (
   // clock and reset
   input  wire  logic               i_mclk,
   input  wire  logic               i_nrst,
   // register port
   input  wire  logic [1:0]         i_reg_addr,
   input  wire  logic [7:0]         i_reg_wdata,
   input  wire  logic               i_reg_wr,
   input  wire  logic               i_reg_rd,
   output var   logic [7:0]         o_reg_rdata,
   // cpu access request
   input  wire  logic               i_req_valid,
   input  wire  mmd_pkg::mmd_req_t  i_req,
   output var   logic               o_ready,
   // access result
   output var   mmd_pkg::mmd_resp_t o_resp,
   // configuration seen by the cpu
   output var   logic               o_upper,
   output var   logic               o_fast
);
   import mmd_pkg::*;

   // ==========================================================
   // state
   mmd_state_t r;
   mmd_state_t next_r;

   mmd_addr_t  eff;
   mmd_tgt_t   tgt;
   logic       no_fetch;
   logic       base;
   logic       req_acc;
   logic       is_fetch;
   logic       acc_fault;
   logic [3:0] acc_clks;

   assign req_acc  = i_req_valid && r.ready;
   assign is_fetch = (i_req.kind == KIND_FETCH);

   // ==========================================================
   // effective address
   always_comb begin
      case (i_req.kind)
         KIND_VEC: begin
            // word slots, index 0 is reset, 1Fh breakpoint
            eff = VEC_BASE | {14'h0000, i_req.idx[4:0], 1'b0};
         end
         KIND_TCALL: begin
            // only 32 entries, upper index bits ignored
            eff = TCALL_BASE | {14'h0000, i_req.idx[4:0], 1'b0};
         end
         KIND_FCALL: begin
            eff = FCALL_BASE | {9'h000, i_req.idx};
         end
         default: begin
            // plain access, vector and table words need no care here
            eff = i_req.addr;
         end
      endcase
   end

   // ==========================================================
   // region decode
   mmd_region u_region (
      .i_addr     (eff),
      .i_upper    (r.upper),
      .i_expand   (r.expand),
      .o_target   (tgt),
      .o_no_fetch (no_fetch),
      .o_base     (base)
   );

   // ==========================================================
   // access length
   always_comb begin
      acc_fault = (tgt == TGT_NONE) || (is_fetch && no_fetch);
      if (acc_fault) begin
         acc_clks = DATA_CLKS;
      end else if ((tgt == TGT_ROM) && is_fetch && r.fast) begin
         acc_clks = FAST_FETCH_CLKS;
      end else if ((tgt == TGT_ROM) || (tgt == TGT_EXT)) begin
         // slow rom fetch pays the same waits as the bus
         acc_clks = EXT_FETCH_CLKS + {2'b00, r.wait_n};
      end else begin
         acc_clks = DATA_CLKS;
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      next_r           = r;
      next_r.resp.done = 1'b0;
      next_r.rdata     = 8'h00;

      case (r.st)
         ST_IDLE: begin
            if (req_acc) begin
               // first access freezes the placement as well
               next_r.locked      = 1'b1;
               next_r.ready       = 1'b0;
               next_r.resp.target = tgt;
               next_r.resp.addr   = eff;
               next_r.resp.base   = base;
               next_r.resp.fault  = acc_fault;
               // bank number sits in the vector word itself
               next_r.resp.vec    = (i_req.kind == KIND_VEC);
               next_r.cnt         = acc_clks;
               next_r.st          = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (r.cnt == 4'h1) begin
               next_r.resp.done = 1'b1;
               next_r.ready     = 1'b1;
               next_r.st        = ST_IDLE;
            end else begin
               next_r.cnt = r.cnt - 4'h1;
            end
         end
         default: begin
            next_r.st    = ST_IDLE;
            next_r.ready = 1'b1;
         end
      endcase

      // register writes
      if (i_reg_wr) begin
         if (i_reg_addr == REG_MODE) begin
            next_r.fast   = i_reg_wdata[MODE_FAST_BIT];
            next_r.expand = i_reg_wdata[MODE_EXP_BIT];
            // waits never stall a fast rom fetch
            next_r.wait_n = i_reg_wdata[MODE_WAIT_LSB +: 2];
         end else if (i_reg_addr == REG_PLACE) begin
            if (!r.locked) begin
               next_r.upper  = i_reg_wdata[PLACE_UP_BIT];
               next_r.locked = 1'b1;
            end
         end else if (i_reg_addr == REG_STATUS) begin
            if (i_reg_wdata[STAT_FLT_BIT]) begin
               next_r.fault_flag = 1'b0;
            end
         end
      end

      // a fault in the clearing cycle is kept
      if (req_acc && acc_fault && (r.st == ST_IDLE)) begin
         next_r.fault_flag = 1'b1;
      end

      // register reads, data stand one cycle
      if (i_reg_rd) begin
         if (i_reg_addr == REG_MODE) begin
            next_r.rdata = {4'h0, r.wait_n, r.expand, r.fast};
         end else if (i_reg_addr == REG_PLACE) begin
            next_r.rdata = {6'h00, r.locked, r.upper};
         end else if (i_reg_addr == REG_STATUS) begin
            next_r.rdata = {4'h0, ~r.ready, r.resp.target, r.fault_flag};
         end else begin
            next_r.rdata = 8'h00;
         end
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         r             <= '0;
         r.st          <= ST_IDLE;
         r.ready       <= 1'b1;
         r.fast        <= MODE_RST[MODE_FAST_BIT];
         r.expand      <= MODE_RST[MODE_EXP_BIT];
         r.wait_n      <= MODE_RST[MODE_WAIT_LSB +: 2];
         r.upper       <= 1'b0;
         r.resp.target <= TGT_NONE;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // outputs
   assign o_reg_rdata = r.rdata;
   assign o_ready     = r.ready;
   assign o_resp      = r.resp;
   assign o_upper     = r.upper;
   assign o_fast      = r.fast;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   logic rom_fetch;
   assign rom_fetch = req_acc && is_fetch && (tgt == TGT_ROM);

   // done shows one edge after the counter expires, so n clocks look like n quiet samples
   sequence s_done_after_two;
      !o_resp.done [*2] ##1 o_resp.done;
   endsequence

   sequence s_done_after_three;
      !o_resp.done [*3] ##1 o_resp.done;
   endsequence

   a_place_hold: assert property (
      r.locked |=> $stable(r.upper) && r.locked)
      else $error("placement changed after lock");

   a_upper_top: assert property (
      req_acc && r.upper && (eff == SPACE_END)
      |=> o_resp.target == TGT_DATA)
      else $error("top address not in data area");

   a_ext_gate: assert property (
      req_acc && !r.expand |=> o_resp.target != TGT_EXT)
      else $error("external bus used without expansion");

   a_data_prio: assert property (
      req_acc && !r.upper && (eff >= DATA_LO) && (eff <= BASE_END)
      |=> o_resp.target == TGT_DATA)
      else $error("rom won over data area");

   a_hidden_rom: assert property (
      req_acc && r.upper && (eff >= DATA_LO) && (eff <= BASE_END)
      |=> o_resp.target == TGT_ROM)
      else $error("hidden rom not reachable");

   a_fast_rom: assert property (
      rom_fetch && r.fast |=> s_done_after_two)
      else $error("fast rom fetch not two clocks");

   a_slow_rom: assert property (
      rom_fetch && !r.fast && (r.wait_n == 2'b00)
      |=> s_done_after_three)
      else $error("slow rom fetch length wrong");

   a_no_fetch: assert property (
      req_acc && is_fetch && no_fetch |=> o_resp.fault)
      else $error("fetch from ram or sfr not refused");

   a_vec_brk: assert property (
      req_acc && (i_req.kind == KIND_VEC) && (i_req.idx[4:0] == 5'h1F)
      |=> o_resp.addr == 20'h0003E)
      else $error("breakpoint vector slot wrong");

   a_vec_range: assert property (
      req_acc && (i_req.kind == KIND_VEC)
      |=> o_resp.addr <= VEC_END && o_resp.vec)
      else $error("vector outside table");

   a_tcall_range: assert property (
      req_acc && (i_req.kind == KIND_TCALL)
      |=> (o_resp.addr >= TCALL_BASE) && (o_resp.addr <= TCALL_END))
      else $error("table call outside table");

   a_fcall_range: assert property (
      req_acc && (i_req.kind == KIND_FCALL)
      |=> (o_resp.addr >= FCALL_BASE) && (o_resp.addr <= FCALL_END))
      else $error("fixed call outside entry area");

   a_one_hold: assert property (
      !r.ready |=> $stable(o_resp.target) && $stable(o_resp.addr))
      else $error("target changed during access");

endmodule : mmd_decoder

`default_nettype wire

// [verification/mmd_cpu_model.sv]
// cpu core model: issues fetch and data accesses to the decoder
`default_nettype none

module mmd_cpu_model
   import mmd_pkg::*;
(
   // clock
   input  wire logic               i_mclk,
   // request side
   output var  logic               o_req_valid,
   output var  mmd_pkg::mmd_req_t  o_req,
   // answer side
   input  wire logic               i_ready,
   input  wire mmd_pkg::mmd_resp_t i_resp
);
   timeunit 1ns;
   timeprecision 1ps;

   mmd_resp_t last_resp;
   int        last_n;

   initial begin
      o_req_valid = 1'b0;
      o_req       = '0;
   end

   // ==========================================================
   // one access: hold until taken, then count clocks to done
   // never expects ram contents, no external wait aimed at rom alone
   task automatic access(input mmd_kind_t kind, input mmd_addr_t addr,
                         input logic [10:0] idx);
      mmd_req_t r;
      int       k;
      r = '{kind, addr, idx};
      k = 0;
      @(posedge i_mclk);
      o_req_valid <= 1'b1;
      o_req       <= r;
      do begin
         @(posedge i_mclk);
         k++;
      end while (!i_ready && k < 100);
      o_req_valid <= 1'b0;
      // released lines carry junk so a late sample cannot pass
      o_req       <= ~r;
      k = 0;
      do begin
         @(posedge i_mclk);
         k++;
      end while (!i_resp.done && k < 100);
      last_resp = i_resp;
      last_n    = k - 1;
   endtask : access

endmodule : mmd_cpu_model

`default_nettype wire

// [verification/mmd_decoder_bench.sv]
// self-checking bench of the memory map decoder
`default_nettype none

module mmd_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mmd_pkg::*;

   logic       mclk      = 1'b0;
   logic       nrst      = 1'b0;
   logic [1:0] reg_addr  = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic [7:0] reg_rdata;
   logic       req_valid;
   mmd_req_t   req;
   logic       ready;
   mmd_resp_t  resp;
   logic       upper;
   logic       fast;
   logic [7:0] d;
   int         fails     = 0;
   int         cmp_count = 0;

   mmd_decoder DUT (
      .i_mclk(mclk), .i_nrst(nrst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
      .i_req_valid(req_valid), .i_req(req), .o_ready(ready), .o_resp(resp),
      .o_upper(upper), .o_fast(fast));

   mmd_cpu_model cpu (
      .i_mclk(mclk), .o_req_valid(req_valid), .o_req(req), .i_ready(ready),
      .i_resp(resp));

   initial begin
      forever #2 mclk = ~mclk;
   end

   // ==========================================================
   // compare and bus tasks
   task automatic chk_val(input string what, input logic [19:0] e, input logic [19:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %0h seen %0h", what, e, g);
      end
   endtask : chk_val

   task automatic chk_tgt(input string what, input mmd_tgt_t e, input mmd_tgt_t g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %0d seen %0d", what, e, g);
      end
   endtask : chk_tgt

   task automatic do_reset();
      nrst <= 1'b0;
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
   endtask : do_reset

   task automatic reg_w(input logic [1:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      // the written value lands at this edge; look one edge later
      @(posedge mclk);
   endtask : reg_w

   // read data stands only in the cycle after the strobe
   task automatic reg_r(input logic [1:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      @(posedge mclk);
      v = reg_rdata;
   endtask : reg_r

   task automatic acc(input mmd_kind_t k, input mmd_addr_t a, input logic [10:0] ix,
                      input mmd_tgt_t tg, input int n, input logic flt, input logic bs);
      cpu.access(k, a, ix);
      chk_val("fault", 20'(flt), 20'(cpu.last_resp.fault));
      chk_val("cycles", 20'(n), 20'(cpu.last_n));
      if (!flt) begin
         chk_tgt("target", tg, cpu.last_resp.target);
         chk_val("base", 20'(bs), 20'(cpu.last_resp.base));
      end
   endtask : acc

   // ==========================================================
   // scenarios
   task automatic t_reset_state();
      chk_val("fast", 20'h0, 20'(fast));
      chk_val("upper", 20'h0, 20'(upper));
      reg_r(REG_MODE, d);
      chk_val("mode", 20'h0, 20'(d));
      reg_r(2'h3, d);
      chk_val("unmapped", 20'h0, 20'(d));
      acc(KIND_FETCH, 20'h00100, 11'h0, TGT_ROM, 3, 1'b0, 1'b1);
   endtask : t_reset_state

   task automatic t_lower();
      acc(KIND_DATA, 20'h0EE00, 11'h0, TGT_DATA, 1, 1'b0, 1'b1);
      acc(KIND_DATA, 20'h0EDFF, 11'h0, TGT_ROM, 3, 1'b0, 1'b1);
      acc(KIND_FETCH, 20'h10000, 11'h0, TGT_ROM, 3, 1'b0, 1'b0);
      acc(KIND_DATA, 20'h20000, 11'h0, TGT_NONE, 1, 1'b1, 1'b0);
      // idle, last target none, fault kept
      reg_r(REG_STATUS, d);
      chk_val("status", 20'h07, 20'(d));
      reg_w(REG_STATUS, 8'h01);
      reg_r(REG_STATUS, d);
      chk_val("status", 20'h06, 20'(d));
      reg_w(REG_MODE, 8'h02);
      acc(KIND_DATA, 20'h20000, 11'h0, TGT_EXT, 3, 1'b0, 1'b0);
      acc(KIND_FETCH, 20'h0FD00, 11'h0, TGT_NONE, 1, 1'b1, 1'b1);
      acc(KIND_FETCH, 20'h0FCFF, 11'h0, TGT_DATA, 1, 1'b0, 1'b1);
   endtask : t_lower

   task automatic t_timing();
      reg_w(REG_MODE, 8'h01);
      chk_val("fast", 20'h1, 20'(fast));
      acc(KIND_FETCH, 20'h00200, 11'h0, TGT_ROM, 2, 1'b0, 1'b1);
      acc(KIND_DATA, 20'h00200, 11'h0, TGT_ROM, 3, 1'b0, 1'b1);
      reg_w(REG_MODE, 8'h0D);
      acc(KIND_FETCH, 20'h00200, 11'h0, TGT_ROM, 2, 1'b0, 1'b1);
      reg_w(REG_MODE, 8'h0C);
      acc(KIND_FETCH, 20'h00200, 11'h0, TGT_ROM, 6, 1'b0, 1'b1);
   endtask : t_timing

   task automatic t_tables();
      logic [10:0] ix [5] = '{11'd0, 11'd1, 11'd2, 11'd30, 11'd31};
      reg_w(REG_MODE, 8'h00);
      for (int i = 0; i < 5; i++) begin
         acc(KIND_VEC, 20'h0, ix[i], TGT_ROM, 3, 1'b0, 1'b1);
         chk_val("vec addr", 20'(ix[i]) * 20'h2, cpu.last_resp.addr);
         chk_val("vec flag", 20'h1, 20'(cpu.last_resp.vec));
      end
      acc(KIND_TCALL, 20'h0, 11'd31, TGT_ROM, 3, 1'b0, 1'b1);
      chk_val("tcall addr", 20'h0007E, cpu.last_resp.addr);
      acc(KIND_FCALL, 20'h0, 11'h7FF, TGT_ROM, 3, 1'b0, 1'b1);
      chk_val("fcall addr", 20'h00FFF, cpu.last_resp.addr);
      acc(KIND_DATA, 20'h00002, 11'h0, TGT_ROM, 3, 1'b0, 1'b1);
      chk_val("vec flag", 20'h0, 20'(cpu.last_resp.vec));
   endtask : t_tables

   task automatic t_upper();
      chk_val("fast", 20'h0, 20'(fast));
      reg_w(REG_PLACE, 8'h01);
      chk_val("upper", 20'h1, 20'(upper));
      reg_r(REG_PLACE, d);
      chk_val("place", 20'h3, 20'(d));
      reg_w(REG_PLACE, 8'h00);
      chk_val("upper", 20'h1, 20'(upper));
      acc(KIND_DATA, 20'h0EE00, 11'h0, TGT_ROM, 3, 1'b0, 1'b1);
      acc(KIND_DATA, 20'hFEE00, 11'h0, TGT_DATA, 1, 1'b0, 1'b0);
      acc(KIND_DATA, 20'hFFFFF, 11'h0, TGT_DATA, 1, 1'b0, 1'b0);
      acc(KIND_DATA, 20'h1FFFF, 11'h0, TGT_ROM, 3, 1'b0, 1'b0);
      acc(KIND_FETCH, 20'hFFD00, 11'h0, TGT_NONE, 1, 1'b1, 1'b0);
      acc(KIND_DATA, 20'hF0000, 11'h0, TGT_NONE, 1, 1'b1, 1'b0);
   endtask : t_upper

   task automatic t_lock();
      acc(KIND_DATA, 20'h00100, 11'h0, TGT_ROM, 3, 1'b0, 1'b1);
      reg_w(REG_PLACE, 8'h01);
      chk_val("upper", 20'h0, 20'(upper));
      acc(KIND_DATA, 20'h0EE00, 11'h0, TGT_DATA, 1, 1'b0, 1'b1);
   endtask : t_lock

   // ==========================================================
   // verdict
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results

   initial begin
      #200000;
      fails++;
      results();
   end

   initial begin
      do_reset();
      t_reset_state();
      t_lower();
      t_timing();
      t_tables();
      do_reset();
      t_upper();
      do_reset();
      t_lock();
      results();
   end

endmodule : mmd_decoder_bench

`default_nettype wire
